// ===== fdc_pkg.sv
// shared constants and types of the floppy byte command front end
package fdc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int STEP_PULSE_NS   = 1000;
  localparam int STEP_PULSE_CYC  = (STEP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STEP_PERIOD_US  = 10000;
  localparam int STEP_PERIOD_CYC = STEP_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int POLL_US         = 100;
  localparam int POLL_CYC        = POLL_US * (CLK_HZ / 1_000_000);
  localparam int STEP_LIMIT      = 80;
  localparam int TIMER_W         = 18;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [1:0] PTR_PAGE  = 2'h1;
  localparam int CTRL_INTMODE = 0;
  localparam int CTRL_BOOT    = 1;
  localparam int CTRL_HEADLD  = 2;
  localparam int CTRL_WRITE   = 3;
  localparam int CTRL_W       = 4;
  localparam int ST_PROT   = 0;
  localparam int ST_READY  = 4;
  localparam int ST_RBUSY  = 8;
  localparam int ST_WEN    = 9;
  localparam int ST_IRQ    = 10;
  localparam int ST_BOOTOK = 11;
  localparam int ST_BUSY   = 12;

  // ----------------------------------------------------------------
  // operations, pointers, command strings
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_EXEC      = 4'h0;
  localparam logic [3:0] OP_LOAD      = 4'h1;
  localparam logic [3:0] OP_RESTORE   = 4'h2;
  localparam logic [3:0] OP_PROTECT   = 4'h3;
  localparam logic [3:0] OP_UNPROTECT = 4'h4;
  localparam logic [3:0] OP_INTCLR    = 4'h5;
  localparam int NUM_PTR = 16;
  localparam int NUM_DRV = 4;
  localparam int CS_LEN  = 7;
  localparam logic [15:0] PTR_STEP   = 16'h1000;
  localparam logic [7:0]  STATUS_OK  = 8'h01;
  localparam int          STATUS_ERR = 7;
  localparam logic [7:0]  BOOT_CMD    = 8'h21;
  localparam logic [7:0]  BOOT_TRACK  = 8'h00;
  localparam logic [7:0]  BOOT_SECTOR = 8'h01;
  localparam logic [15:0] BOOT_BUF    = 16'h0000;

  typedef enum logic [1:0] {B_OP = 2'b00, B_LO = 2'b01, B_HI = 2'b10} byte_state_t;
  typedef enum logic [2:0] {
    X_IDLE = 3'b000, X_FETCH = 3'b001, X_RUN = 3'b010, X_WAIT = 3'b011, X_STORE = 3'b100
  } exec_state_t;
  typedef enum logic [1:0] {
    D_POLL = 2'b00, D_CHECK = 2'b01, D_STEP = 2'b10, D_SETTLE = 2'b11
  } drv_state_t;

endpackage : fdc_pkg

// ===== drive_seq.sv
// drive select polling and head restore sequencer
`timescale 1ns/1ps
module drive_seq
  import fdc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_PERIOD_CYC
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic [NUM_DRV-1:0] restoreMask,
  input  wire logic               readyPin,
  input  wire logic               trackZeroPin,
  output logic      [NUM_DRV-1:0] selectOut,
  output logic      [NUM_DRV-1:0] readyFlags,
  output logic                    stepOut,
  output logic                    dirOut,
  output logic                    busy
);

  if (STEP_CYCLES <= STEP_PULSE_CYC || STEP_CYCLES >= 2**TIMER_W) begin : g_chk
    $error("drive_seq: STEP_CYCLES out of range");
  end

  logic [1:0]         rdySync_reg;
  logic [1:0]         tzSync_reg;
  drv_state_t         state_reg;
  logic [1:0]         cur_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [NUM_DRV-1:0] pend_reg;
  logic [6:0]         steps_reg;
  logic               rdy;
  logic               tz;
  logic               expire;
  logic [NUM_DRV-1:0] newReady;
  logic [NUM_DRV-1:0] done;
  logic [NUM_DRV-1:0] pend_next;

  assign rdy = rdySync_reg[1];
  assign tz  = tzSync_reg[1];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdySync_reg <= 2'h0;
      tzSync_reg  <= 2'h0;
    end else begin
      rdySync_reg <= {rdySync_reg[0], readyPin};
      tzSync_reg  <= {tzSync_reg[0], trackZeroPin};
    end
  end

  always_comb begin
    expire = 1'b0;
    case (state_reg)
      D_POLL:   expire = timer_reg == TIMER_W'(POLL_CYC - 1);
      D_STEP:   expire = timer_reg == TIMER_W'(STEP_PULSE_CYC - 1);
      D_SETTLE: expire = timer_reg == TIMER_W'(STEP_CYCLES - 1);
      default:  expire = 1'b1;
    endcase
  end

  // ready only means anything for the selected drive
  assign newReady = (state_reg == D_POLL && expire && rdy && !readyFlags[cur_reg])
                    ? NUM_DRV'(1) << cur_reg : '0;
  assign done = (state_reg == D_CHECK && (tz || steps_reg == 7'(STEP_LIMIT)))
                ? NUM_DRV'(1) << cur_reg : '0;
  // a request landing on the finishing cycle is kept
  assign pend_next = (pend_reg & ~done) | newReady | restoreMask;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg   <= '0;
      readyFlags <= '0;
    end else begin
      pend_reg <= pend_next;
      if (state_reg == D_POLL && expire) begin
        readyFlags[cur_reg] <= rdy;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= D_POLL;
      cur_reg   <= 2'h0;
      timer_reg <= '0;
      steps_reg <= 7'h0;
      stepOut   <= 1'b0;
      selectOut <= NUM_DRV'(1);
      dirOut    <= 1'b0;
      busy      <= 1'b0;
    end else begin
      timer_reg <= expire ? '0 : timer_reg + 1'b1;
      case (state_reg)
        D_POLL: begin
          if (expire) begin
            // dwell covers the synchroniser delay after a select change
            if (pend_next[cur_reg]) begin
              state_reg <= D_CHECK;
              busy      <= 1'b1;
              dirOut    <= 1'b1;
              steps_reg <= 7'h0;
            end else begin
              cur_reg   <= cur_reg + 1'b1;
              selectOut <= NUM_DRV'(1) << (cur_reg + 1'b1);
            end
          end
        end
        D_CHECK: begin
          if (tz || steps_reg == 7'(STEP_LIMIT)) begin
            state_reg <= D_POLL;
            busy      <= 1'b0;
            dirOut    <= 1'b0;
          end else begin
            state_reg <= D_STEP;
            stepOut   <= 1'b1;
            steps_reg <= steps_reg + 1'b1;
          end
        end
        D_STEP: begin
          if (expire) begin
            stepOut   <= 1'b0;
            state_reg <= D_SETTLE;
          end
        end
        default: begin
          if (expire) begin
            state_reg <= D_CHECK;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_step_width: assert property ($rose(stepOut) |-> stepOut [*8])
    else $error("step pulse too short");
  a_restore_stop: assert property (state_reg == D_CHECK && tz |=> !stepOut && !busy)
    else $error("step issued over track zero");

endmodule : drive_seq

// ===== floppy_byte_cmd.sv
// byte command front end: apb port, pointer table, command string fetch, boot
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// - host byte: bits 7..4 operation, bits 3..0 pointer or drive mask.
// - operation 0 runs the command string at the named pointer's address.
// - operation 0 first fetches the command string over dma.
// - operation 1 takes the next two bytes as the pointer's new address.
// - operation 2 restores each masked drive to track zero.
// - operation 3 write-protects masked drives; writes to them are refused.
// - protect flags clear at power-on; host reissues protection.
// - operation 4 clears protect flags of masked drives.
// - operations 5 to 15 only clear a pending interrupt.
// - reset loads pointer n with n times 1000 hex.
// - mask bit n selects drive n; several drives allowed.
// - operations 2 to 4 with empty mask do nothing.
// - drive selects are polled in turn for readiness; polling pauses while a restore runs.
// - a drive that becomes ready is restored automatically.
// - head-load and write lines are driven on request.
// - boot reads drive 0 track 0 sector 1 to 0..7f, then runs 0.
// - boot errors show on the lights and the boot retries.
// - finished string gets a nonzero status; bit 7 fail, bit 0 ok.
// ----------------------------------------------------------------
module floppy_byte_cmd
  import fdc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_PERIOD_CYC
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    dmaReq,
  output logic                    dmaWrite,
  output logic      [15:0]        dmaAddr,
  output logic      [7:0]         dmaWdata,
  input  wire logic               dmaAck,
  input  wire logic [7:0]         dmaRdata,
  output logic                    execStart,
  output logic      [7:0]         execCmd,
  output logic      [7:0]         execTrack,
  output logic      [7:0]         execSector,
  output logic      [15:0]        execBuf,
  input  wire logic               execDone,
  input  wire logic [7:0]         execStatus,
  input  wire logic               readyPin,
  input  wire logic               trackZeroPin,
  input  wire logic               writeEnPin,
  output logic      [NUM_DRV-1:0] driveSelect,
  output logic                    stepPulse,
  output logic                    stepDir,
  output logic                    headLoad,
  output logic                    writeGate,
  output logic                    irq,
  output logic      [7:0]         lights,
  output logic                    bootJump
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  byte_state_t        byteState;
  exec_state_t        xState;
  logic [15:0]        ptrReg [NUM_PTR];
  logic [3:0]         ptrIdx_reg;
  logic [7:0]         lo_reg;
  logic [NUM_DRV-1:0] protectReg;
  logic [CTRL_W-1:0]  ctrl_reg;
  logic [15:0]        base_reg;
  logic [2:0]         idx_reg;
  logic [7:0]         cs_reg [CS_LEN];
  logic               bootAct_reg;
  logic               bootOk_reg;
  logic [1:0]         wenSync_reg;
  logic [NUM_DRV-1:0] restoreMask_reg;
  logic [NUM_DRV-1:0] readyFlags;
  logic               restoreBusy;

  logic               wrFire;
  logic               opFire;
  logic               opValid;
  logic [3:0]         op;
  logic [3:0]         arg;
  logic [31:0]        rdata_next;
  logic               err_next;
  logic [31:0]        statusWord;
  logic               storeDone;
  logic               irq_next;

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ----------------------------------------------------------------
  assign wrFire  = psel && penable && pready && pwrite;
  assign opFire  = wrFire && paddr == ADDR_CMD;
  assign opValid = opFire && byteState == B_OP;
  assign op      = pwdata[7:4];
  assign arg     = pwdata[3:0];

  always_comb begin
    statusWord                    = 32'h0;
    statusWord[ST_PROT +: 4]      = protectReg;
    statusWord[ST_READY +: 4]     = readyFlags;
    statusWord[ST_RBUSY]          = restoreBusy;
    statusWord[ST_WEN]            = wenSync_reg[1];
    statusWord[ST_IRQ]            = irq;
    statusWord[ST_BOOTOK]         = bootOk_reg;
    statusWord[ST_BUSY]           = xState != X_IDLE;
  end

  always_comb begin
    rdata_next = 32'h0;
    err_next   = 1'b0;
    if (paddr == ADDR_CMD) begin
      rdata_next = {30'h0, byteState};
    end else if (paddr == ADDR_CTRL) begin
      rdata_next = {28'h0, ctrl_reg};
    end else if (paddr == ADDR_STAT) begin
      rdata_next = statusWord;
    end else if (paddr[7:6] == PTR_PAGE && paddr[1:0] == 2'h0) begin
      rdata_next = {16'h0, ptrReg[paddr[5:2]]};
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && err_next;
      prdata  <= (psel && penable && !pready && !pwrite) ? rdata_next : 32'h0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
    end else if (wrFire && paddr == ADDR_CTRL) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // byte decode and pointer table
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      byteState  <= B_OP;
      ptrIdx_reg <= 4'h0;
      lo_reg     <= 8'h0;
    end else if (opFire) begin
      case (byteState)
        B_OP: begin
          if (op == OP_LOAD) begin
            ptrIdx_reg <= arg;
            byteState  <= B_LO;
          end
        end
        B_LO: begin
          lo_reg    <= pwdata[7:0];
          byteState <= B_HI;
        end
        default: begin
          byteState <= B_OP;
        end
      endcase
    end
  end

  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        ptrReg[i] <= PTR_STEP * 16'(i);
      end else if (opFire && byteState == B_HI && ptrIdx_reg == 4'(i)) begin
        ptrReg[i] <= {pwdata[7:0], lo_reg};
      end
    end
  end

  // an all-zero mask leaves every flag as it was
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      protectReg <= '0;
    end else if (opValid && op == OP_PROTECT) begin
      protectReg <= protectReg | arg;
    end else if (opValid && op == OP_UNPROTECT) begin
      protectReg <= protectReg & ~arg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      restoreMask_reg <= '0;
    end else begin
      restoreMask_reg <= (opValid && op == OP_RESTORE) ? arg : '0;
    end
  end

  // ----------------------------------------------------------------
  // command string fetch, execution hand-off, status write-back
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      xState      <= X_IDLE;
      base_reg    <= 16'h0;
      idx_reg     <= 3'h0;
      dmaReq      <= 1'b0;
      dmaWrite    <= 1'b0;
      dmaAddr     <= 16'h0;
      dmaWdata    <= 8'h0;
      execStart   <= 1'b0;
      execCmd     <= 8'h0;
      execTrack   <= 8'h0;
      execSector  <= 8'h0;
      execBuf     <= 16'h0;
      bootAct_reg <= 1'b0;
      bootOk_reg  <= 1'b0;
      bootJump    <= 1'b0;
      lights      <= 8'h0;
    end else begin
      execStart <= 1'b0;
      if (!ctrl_reg[CTRL_BOOT]) begin
        bootOk_reg <= 1'b0;
        bootJump   <= 1'b0;
      end
      case (xState)
        X_IDLE: begin
          // an execute byte while busy is dropped; the host polls status
          if (opValid && op == OP_EXEC) begin
            base_reg <= ptrReg[arg];
            dmaAddr  <= ptrReg[arg];
            dmaReq   <= 1'b1;
            idx_reg  <= 3'h0;
            xState   <= X_FETCH;
          end else if (ctrl_reg[CTRL_BOOT] && !bootOk_reg) begin
            bootAct_reg <= 1'b1;
            xState      <= X_RUN;
          end
        end
        X_FETCH: begin
          if (dmaAck) begin
            cs_reg[idx_reg] <= dmaRdata;
            if (idx_reg == 3'(CS_LEN - 1)) begin
              dmaReq <= 1'b0;
              xState <= X_RUN;
            end else begin
              idx_reg <= idx_reg + 1'b1;
              dmaAddr <= base_reg + 16'(idx_reg) + 16'h1;
            end
          end
        end
        X_RUN: begin
          execStart  <= 1'b1;
          // byte 3 carries the track and byte 4 the sector; bytes 1 and 2 are not used
          execCmd    <= bootAct_reg ? BOOT_CMD : cs_reg[0];
          execTrack  <= bootAct_reg ? BOOT_TRACK : cs_reg[3];
          execSector <= bootAct_reg ? BOOT_SECTOR : cs_reg[4];
          execBuf    <= bootAct_reg ? BOOT_BUF : {cs_reg[6], cs_reg[5]};
          xState     <= X_WAIT;
        end
        X_WAIT: begin
          if (execDone) begin
            xState <= X_IDLE;
            if (bootAct_reg) begin
              bootAct_reg <= 1'b0;
              if (execStatus[STATUS_ERR]) begin
                lights <= execStatus;
              end else begin
                bootOk_reg <= 1'b1;
                bootJump   <= 1'b1;
              end
            end else begin
              dmaReq   <= 1'b1;
              dmaWrite <= 1'b1;
              dmaAddr  <= base_reg + 16'h1;
              dmaWdata <= execStatus[STATUS_ERR] ? execStatus : STATUS_OK;
              xState   <= X_STORE;
            end
          end
        end
        default: begin
          if (dmaAck) begin
            dmaReq   <= 1'b0;
            dmaWrite <= 1'b0;
            xState   <= X_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt request, drive lines
  // ----------------------------------------------------------------
  assign storeDone = xState == X_STORE && dmaAck;
  // completion in the clearing cycle wins so no completion is lost
  assign irq_next  = (storeDone && ctrl_reg[CTRL_INTMODE])
                     || (irq && !(opValid && op >= OP_INTCLR));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq         <= 1'b0;
      wenSync_reg <= 2'h0;
      headLoad    <= 1'b0;
      writeGate   <= 1'b0;
    end else begin
      irq         <= irq_next;
      wenSync_reg <= {wenSync_reg[0], writeEnPin};
      headLoad    <= ctrl_reg[CTRL_HEADLD];
      writeGate   <= ctrl_reg[CTRL_WRITE] && (driveSelect & protectReg) == '0;
    end
  end

  drive_seq #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_drive (
    .clock        (clock),
    .arst_n       (arst_n),
    .restoreMask  (restoreMask_reg),
    .readyPin     (readyPin),
    .trackZeroPin (trackZeroPin),
    .selectOut    (driveSelect),
    .readyFlags   (readyFlags),
    .stepOut      (stepPulse),
    .dirOut       (stepDir),
    .busy         (restoreBusy)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_load_enter: assert property (opValid && op == OP_LOAD |=> byteState == B_LO)
    else $error("load byte not followed by address phase");
  a_ptr_write: assert property (opFire && byteState == B_HI
      |=> ptrReg[ptrIdx_reg] == {$past(pwdata[7:0]), lo_reg})
    else $error("pointer not loaded low then high");
  a_prot_set: assert property (opValid && op == OP_PROTECT
      |=> (protectReg & $past(arg)) == $past(arg))
    else $error("protect flag not set");
  a_prot_clr: assert property (opValid && op == OP_UNPROTECT
      |=> (protectReg & $past(arg)) == '0)
    else $error("protect flag not cleared");
  a_mask_empty: assert property (opValid && arg == 4'h0
      && (op == OP_PROTECT || op == OP_UNPROTECT) |=> $stable(protectReg))
    else $error("empty mask changed protection");
  a_exec_fetch: assert property (opValid && op == OP_EXEC && xState == X_IDLE
      |=> dmaReq && !dmaWrite && dmaAddr == ptrReg[$past(arg)])
    else $error("execute did not start fetch at pointer");
  a_status_code: assert property (dmaReq && dmaWrite
      |-> dmaWdata[STATUS_ERR] || dmaWdata == STATUS_OK)
    else $error("bad completion status");
  a_irq_clear: assert property (opValid && op >= OP_INTCLR && !storeDone |=> !irq)
    else $error("interrupt not cleared");
  a_write_block: assert property (writeGate
      |-> ($past(driveSelect) & $past(protectReg)) == '0)
    else $error("write to protected drive");

endmodule : floppy_byte_cmd

// ===== host_mem_model.sv
// behavioural host memory and string executor beside the front end
`timescale 1ns/1ps
module host_mem_model (
  input  wire logic        clock,
  input  wire logic        dmaReq,
  input  wire logic        dmaWrite,
  input  wire logic [15:0] dmaAddr,
  input  wire logic [7:0]  dmaWdata,
  output logic             dmaAck,
  output logic      [7:0]  dmaRdata,
  input  wire logic        execStart,
  output logic             execDone,
  output logic      [7:0]  execStatus,
  input  wire logic [7:0]  execStat
);
  int          nRd = 0;
  int          nWr = 0;
  int          dly = 0;
  int          cnt = 0;
  logic [15:0] firstAddr = 16'h0;
  logic [15:0] lastAddr = 16'h0;
  logic [7:0]  lastData = 8'h0;
  initial {dmaAck, dmaRdata, execDone, execStatus} = 18'h0;
  // odd addresses answer slowly; idle data toggles so it is never mistaken for a beat
  always @(posedge clock) begin
    dmaAck <= 1'h0;
    dmaRdata <= ~dmaRdata;
    execDone <= 1'h0;
    if (dmaReq && !dmaAck) begin
      dly <= dly + 1;
      if (dly >= 2 * dmaAddr[0]) begin
        dmaAck <= 1'h1;
        dly <= 0;
        // host cleared the status byte and keeps byte 2 zero before issuing
        dmaRdata <= ((dmaAddr - firstAddr) inside {16'h1, 16'h2}) ? 8'h00 : dmaAddr[7:0];
        if (dmaWrite) begin
          nWr <= nWr + 1;
          lastAddr <= dmaAddr;
          lastData <= dmaWdata;
        end else begin
          nRd <= nRd + 1;
          if (nRd == 0) firstAddr <= dmaAddr;
        end
      end
    end
    if (execStart) cnt <= 3;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      execDone <= 1'h1;
      execStatus <= execStat;
    end
  end
endmodule : host_mem_model

// ===== floppy_byte_command_interpreter_tb.sv
// self-checking bench for the byte command front end
`timescale 1ns/1ps
module floppy_byte_command_interpreter_tb;
  import fdc_pkg::*;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, dmaReq, dmaWrite, err;
  logic        dmaAck, execStart, execDone, readyPin, trackZeroPin, writeEnPin, stepPulse;
  logic        stepDir, headLoad, writeGate, irq, bootJump;
  logic [7:0]  paddr, dmaWdata, dmaRdata, execCmd, execTrack, execSector, execStatus, lights;
  logic [7:0]  execStat;
  logic [15:0] dmaAddr, execBuf;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  driveSelect;
  logic [3:0]  loaded = 4'h0;
  logic [7:0]  st [2] = '{8'h00, 8'h84};
  logic [7:0]  ex [2] = '{8'h01, 8'h84};
  int          err_count = 0;
  int          checks = 0;
  floppy_byte_cmd #(.STEP_CYCLES(40)) uut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dmaReq, .dmaWrite, .dmaAddr, .dmaWdata, .dmaAck,
    .dmaRdata, .execStart, .execCmd, .execTrack, .execSector, .execBuf, .execDone,
    .execStatus, .readyPin, .trackZeroPin, .writeEnPin, .driveSelect, .stepPulse, .stepDir,
    .headLoad, .writeGate, .irq, .lights, .bootJump);
  host_mem_model mdl (.clock, .dmaReq, .dmaWrite, .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata,
    .execStart, .execDone, .execStatus, .execStat);
  // a drive shows ready only while selected with a diskette in it
  always @(posedge clock) readyPin <= (driveSelect & loaded) != 4'h0;
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  // ----
  // apb master, compare, closing
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb
  task automatic op(input logic [7:0] b);
    apb(1'h1, ADDR_CMD, {24'h0, b});
  endtask : op
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    test_done();
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, execStat} = 52'h0;
    trackZeroPin = 1'h0;
    writeEnPin = 1'h1;
    repeat (16) @(posedge clock);
    arst_n <= 1'h1;
    @(posedge clock);
    for (int i = 0; i < NUM_PTR; i++) begin
      apb(1'h0, 8'h40 + 8'(4 * i), 32'h0);
      chk("pointer", 32'(i) * 32'h1000, rd);
    end
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("protect", 32'h0, rd & 32'hf);
    apb(1'h0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("reset test done");
    op(8'h35);
    op(8'h30);
    op(8'h41);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("protect", 32'h4, rd & 32'hf);
    $display("protect test done");
    op(8'h22);
    for (int i = 0; i < 9000 && stepPulse !== 1'h1; i++) @(posedge clock);
    chk("stepDir", 32'h1, {31'h0, stepDir});
    trackZeroPin <= 1'h1;
    $display("restore test done");
    op(8'h12);
    apb(1'h0, ADDR_CMD, 32'h0);
    chk("decode", 32'h1, rd & 32'h3);
    op(8'h34);
    op(8'h12);
    apb(1'h0, 8'h48, 32'h0);
    chk("pointer", 32'h1234, rd);
    apb(1'h1, ADDR_CTRL, 32'hd);
    @(posedge clock);
    chk("headLoad", 32'h1, {31'h0, headLoad});
    for (int k = 0; k < 2; k++) begin
      execStat <= st[k];
      op(8'h02);
      for (int i = 0; i < 400 && mdl.nWr == k; i++) @(posedge clock);
      chk("reads", 32'(7 * (k + 1)), 32'(mdl.nRd));
      chk("fetch", 32'h1234, 32'(mdl.firstAddr));
      chk("status", 32'(ex[k]), 32'(mdl.lastData));
      chk("where", 32'h1235, 32'(mdl.lastAddr));
    end
    chk("exec", 32'h34373839, {execCmd, execTrack, execSector, execBuf[7:0]});
    chk("execBuf", 32'h3a39, 32'(execBuf));
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("irq", 32'h1, 32'(rd[ST_IRQ]));
    op(8'h50);
    chk("irq", 32'h0, {31'h0, irq});
    $display("string test done");
    for (int i = 0; i < 9000 && driveSelect !== 4'h4; i++) @(posedge clock);
    @(posedge clock);
    chk("driveSelect", 32'h4, 32'(driveSelect));
    chk("writeGate", 32'h0, {31'h0, writeGate});
    trackZeroPin <= 1'h0;
    loaded <= 4'h8;
    for (int i = 0; i < 9000 && stepPulse !== 1'h1; i++) @(posedge clock);
    chk("autoRestore", 32'h8, 32'(driveSelect));
    chk("writeGate", 32'h1, {31'h0, writeGate});
    trackZeroPin <= 1'h1;
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("ready", 32'h8, 32'(rd[7:4]));
    chk("writeEn", 32'h1, 32'(rd[ST_WEN]));
    $display("drive test done");
    execStat <= 8'h90;
    apb(1'h1, ADDR_CTRL, 32'h2);
    repeat (12) @(posedge clock);
    chk("lights", 32'h90, 32'(lights));
    execStat <= 8'h01;
    for (int i = 0; i < 100 && bootJump !== 1'h1; i++) @(posedge clock);
    chk("bootJump", 32'h1, {31'h0, bootJump});
    chk("boot", {BOOT_CMD, BOOT_SECTOR, BOOT_BUF}, {execCmd, execSector, execBuf});
    chk("bootTrack", 32'(BOOT_TRACK), 32'(execTrack));
    $display("boot test done");
    test_done();
  end
endmodule : floppy_byte_command_interpreter_tb
